// *** logic/plcfg_pkg.sv ***
package plcfg_pkg;
  // APB register byte addresses
  localparam logic [11:0] ADDR_SRC_DBL = 12'h000;
  localparam logic [11:0] ADDR_LPF = 12'h004;
  localparam logic [11:0] ADDR_POLE3 = 12'h008;
  localparam logic [11:0] ADDR_LOCK = 12'h00C;
  localparam logic [11:0] ADDR_STATUS = 12'h010;
  // Source / doubler fields
  localparam int SRC_SEL_BIT = 1;
  localparam int DBL_EN_BIT = 0;
  localparam logic [7:0] SRC_DBL_RST = 8'h01;
  localparam logic [7:0] SRC_DBL_MASK = 8'h03;
  // Loop filter fields
  localparam int VCO_BYP_BIT = 7;
  localparam int POLE_CAP_LSB = 4;
  localparam int FILT_RES_LSB = 0;
  localparam logic [7:0] LPF_RST = 8'h76;
  localparam logic [7:0] LPF_MASK = 8'hFF;
  // Third pole fields
  localparam int P3_SKIP_BIT = 7;
  localparam int P3_RES_LSB = 4;
  localparam int P3_CAP_LSB = 0;
  localparam logic [7:0] POLE3_RST = 8'h37;
  localparam logic [7:0] POLE3_MASK = 8'hF7;
  // Lock register fields
  localparam int RAW_PIN_BIT = 9;
  localparam int PREC_EN_BIT = 8;
  localparam int TIMER_LSB = 6;
  localparam int STICKY_BIT = 5;
  localparam int CAL_RUN_BIT = 4;
  localparam int LCK_BYP_BIT = 3;
  localparam int LD_RES_LSB = 0;
  localparam logic [15:0] LOCK_RST = 16'h0180;
  localparam logic [15:0] LOCK_MASK = 16'h03FF;
  // Debounce intervals in system clock cycles
  localparam int DEB_CYC1 = 570;
  localparam int DEB_CYC2 = 5700;
  localparam int DEB_CYC3 = 57000;
endpackage

// *** logic/plcfg_sync.sv ***
module plcfg_sync
  import plcfg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic asyncIn,
  output logic syncOut
);
  logic s1_q, s2_q, s3_q, out_q;
  logic out_d;

  always_comb begin
    out_d = out_q;
    // Output takes the third stage once the second and third stages agree
    if (s2_q == s3_q) begin
      out_d = s3_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      s1_q <= asyncIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign syncOut = out_q;
endmodule

// *** logic/plcfg_debounce.sv ***
module plcfg_debounce
  import plcfg_pkg::*;
#(
  parameter int CYC1 = DEB_CYC1,
  parameter int CYC2 = DEB_CYC2,
  parameter int CYC3 = DEB_CYC3
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic rawIn,
  input wire logic [1:0] timerSel,
  output logic stableOut
);
  if (CYC1 < 1 || CYC2 < 1 || CYC3 < 1 || CYC3 >= 65536) begin : g_cycCheck
    $error("plcfg_debounce: interval out of range");
  end

  logic [15:0] cnt_q, cnt_d, target;
  logic out_q, out_d;

  always_comb begin
    unique case (timerSel)
      2'h0: target = 16'h0000;
      2'h1: target = 16'(CYC1);
      2'h2: target = 16'(CYC2);
      2'h3: target = 16'(CYC3);
    endcase
  end

  always_comb begin
    cnt_d = cnt_q;
    out_d = out_q;
    if (!rawIn) begin
      cnt_d = 16'h0000; // RULE16
      out_d = 1'b0;
    end else if (cnt_q >= target) begin
      out_d = 1'b1; // RULE16
    end else begin
      cnt_d = cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_q <= 16'h0000;
      out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign stableOut = out_q;
endmodule

// *** logic/plcfg_top.sv ***
// Function
// [RULE1] Source select bit routes the crystal reference when 0, external clock when 1; reset 0.
// [RULE2] Bit 0 of the source/doubler register enables the frequency doubler; reset 1.
// [RULE3] Loop filter bit 7 bypasses the VCO current source filter when 1.
// [RULE4] Loop filter bits 6:4 give the pole capacitor code to the analog filter; reset 7.
// [RULE5] Loop filter bits 3:0 give the filter resistor code to the analog filter; reset 6.
// [RULE6] Software sets the third-pole skip bit only in integer feedback mode.
// [RULE7] Third-pole bits 6:4 give the third-pole resistor code; reset 3.
// [RULE8] Third-pole bits 2:0 give the third-pole capacitor code; reset 7.
// [RULE9] Lock bit 9 sends the undebounced selected lock to the lock status pin.
// [RULE10] Lock bit 8 selects the precision detector; reset 1.
// [RULE11] Lock bits 7:6 pick debounce of none, 570, 5700 or 57000 cycles; reset code 2.
// [RULE12] Lock bit 5 at 1 keeps lock asserted once it has asserted.
// [RULE13] Lock bit 4 at 0 starts detection only after calibration completes.
// [RULE14] Lock bit 3 at 1 disables the detector and forces lock asserted.
// [RULE15] Lock bits 2:0 select the lock-detect RC filter resistor.
// [RULE16] Debounced lock asserts only after raw lock holds the whole interval.
// [RULE17] Reserved bits read zero and ignore writes.
//
// Decided for this implementation: the APB interface to the registers and the address map.
module plcfg_top
  import plcfg_pkg::*;
#(
  parameter int DEB1 = DEB_CYC1,
  parameter int DEB2 = DEB_CYC2,
  parameter int DEB3 = DEB_CYC3
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog side inputs
  input wire logic precLockRaw,
  input wire logic origLockRaw,
  input wire logic calDone,
  // Analog side controls
  output logic refSelExternal,
  output logic doublerEn,
  output logic vcoFilterBypass,
  output logic [2:0] pole_cap_code,
  output logic [3:0] filter_resistor_code,
  output logic third_pole_skip,
  output logic [2:0] third_pole_resistor_code,
  output logic [2:0] third_pole_cap_code,
  output logic precisionSelect,
  output logic [2:0] lockFilterResCode,
  output logic lockPin,
  output logic pllLocked
);
  if (DEB1 < 1 || DEB2 < 1 || DEB3 < 1 || DEB3 >= 65536) begin : g_debCheck
    $error("plcfg_top: debounce count out of range");
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0] srcDbl_q, srcDbl_d;
  logic [7:0] lpf_q, lpf_d;
  logic [7:0] pole3_q, pole3_d;
  logic [15:0] lock_q, lock_d;
  logic [31:0] rdata_q, rdata_d;
  logic rdy_q, rdy_d, err_q, err_d;
  logic wrEn, mapped;
  logic lockedNow;
  logic precS, origS, calDoneS;

  assign wrEn = psel && penable && pwrite && !rdy_q;

  always_comb begin
    unique case (paddr)
      ADDR_SRC_DBL, ADDR_LPF, ADDR_POLE3, ADDR_LOCK, ADDR_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    srcDbl_d = srcDbl_q;
    lpf_d = lpf_q;
    pole3_d = pole3_q;
    lock_d = lock_q;
    if (wrEn && pstrb[0]) begin
      unique case (paddr)
        ADDR_SRC_DBL: srcDbl_d = pwdata[7:0] & SRC_DBL_MASK; // RULE17
        ADDR_LPF: lpf_d = pwdata[7:0] & LPF_MASK;
        ADDR_POLE3: pole3_d = pwdata[7:0] & POLE3_MASK; // RULE17
        ADDR_LOCK: lock_d[7:0] = pwdata[7:0];
        default: ;
      endcase
    end
    if (wrEn && pstrb[1] && paddr == ADDR_LOCK) begin
      lock_d[15:8] = pwdata[15:8] & LOCK_MASK[15:8]; // RULE17
    end
  end

  // One wait state: answer in the cycle after the access phase starts
  always_comb begin
    rdy_d = psel && penable && !rdy_q;
    err_d = psel && penable && !rdy_q && !mapped;
    rdata_d = 32'h0000_0000;
    if (psel && penable && !rdy_q && !pwrite) begin
      unique case (paddr)
        ADDR_SRC_DBL: rdata_d = {24'h000000, srcDbl_q};
        ADDR_LPF: rdata_d = {24'h000000, lpf_q};
        ADDR_POLE3: rdata_d = {24'h000000, pole3_q};
        ADDR_LOCK: rdata_d = {16'h0000, lock_q};
        ADDR_STATUS: rdata_d = {30'h0000_0000, calDoneS, lockedNow};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      srcDbl_q <= SRC_DBL_RST; // RULE1 RULE2
      lpf_q <= LPF_RST; // RULE4 RULE5
      pole3_q <= POLE3_RST; // RULE7 RULE8
      lock_q <= LOCK_RST; // RULE10 RULE11
      rdata_q <= 32'h0000_0000;
      rdy_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      srcDbl_q <= srcDbl_d;
      lpf_q <= lpf_d;
      pole3_q <= pole3_d;
      lock_q <= lock_d;
      rdata_q <= rdata_d;
      rdy_q <= rdy_d;
      err_q <= err_d;
    end
  end

  assign prdata = rdata_q;
  assign pready = rdy_q;
  assign pslverr = err_q;

  // ----------------------------------------
  // Lock detection
  // ----------------------------------------
  logic rawSel, detGate, rawLock, debLock;
  logic sticky_q, sticky_d;
  logic pin_q, pin_d, lkd_q, lkd_d;

  plcfg_sync u_syncPrec (.ref_clk(ref_clk), .sys_rst(sys_rst), .asyncIn(precLockRaw),
    .syncOut(precS));
  plcfg_sync u_syncOrig (.ref_clk(ref_clk), .sys_rst(sys_rst), .asyncIn(origLockRaw),
    .syncOut(origS));
  plcfg_sync u_syncCal (.ref_clk(ref_clk), .sys_rst(sys_rst), .asyncIn(calDone),
    .syncOut(calDoneS));

  always_comb begin
    rawSel = lock_q[PREC_EN_BIT] ? precS : origS; // RULE10
    detGate = lock_q[CAL_RUN_BIT] || calDoneS; // RULE13
    rawLock = rawSel && detGate;
  end

  plcfg_debounce #(.CYC1(DEB1), .CYC2(DEB2), .CYC3(DEB3)) u_deb (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .rawIn(rawLock),
    .timerSel(lock_q[TIMER_LSB +: 2]), // RULE11
    .stableOut(debLock)
  );

  always_comb begin
    sticky_d = sticky_q;
    // Sticky state is cleared by leaving one-time mode
    if (!lock_q[STICKY_BIT]) begin
      sticky_d = 1'b0;
    end else if (debLock) begin
      sticky_d = 1'b1; // RULE12
    end
    lockedNow = lock_q[LCK_BYP_BIT] || debLock || sticky_q; // RULE14 RULE12
    lkd_d = lockedNow;
    pin_d = lock_q[RAW_PIN_BIT] ? rawSel : lockedNow; // RULE9
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sticky_q <= 1'b0;
      lkd_q <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      sticky_q <= sticky_d;
      lkd_q <= lkd_d;
      pin_q <= pin_d;
    end
  end

  assign pllLocked = lkd_q;
  assign lockPin = pin_q;

  // ----------------------------------------
  // Analog controls
  // ----------------------------------------
  assign refSelExternal = srcDbl_q[SRC_SEL_BIT]; // RULE1
  assign doublerEn = srcDbl_q[DBL_EN_BIT]; // RULE2
  assign vcoFilterBypass = lpf_q[VCO_BYP_BIT]; // RULE3
  assign pole_cap_code = lpf_q[POLE_CAP_LSB +: 3]; // RULE4
  assign filter_resistor_code = lpf_q[FILT_RES_LSB +: 4]; // RULE5
  // Not interlocked with feedback mode; software must keep it legal
  assign third_pole_skip = pole3_q[P3_SKIP_BIT]; // RULE6
  assign third_pole_resistor_code = pole3_q[P3_RES_LSB +: 3]; // RULE7
  assign third_pole_cap_code = pole3_q[P3_CAP_LSB +: 3]; // RULE8
  assign precisionSelect = lock_q[PREC_EN_BIT]; // RULE10
  assign lockFilterResCode = lock_q[LD_RES_LSB +: 3]; // RULE15

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Raw run length; debounce counter can never exceed it
  logic [15:0] runLen_q, runLen_d, debNeed;

  always_comb begin
    runLen_d = 16'h0000;
    if (rawLock) begin
      runLen_d = (runLen_q == 16'hFFFF) ? runLen_q : runLen_q + 16'h0001;
    end
    unique case (lock_q[TIMER_LSB +: 2])
      2'h0: debNeed = 16'h0000;
      2'h1: debNeed = 16'(DEB1);
      2'h2: debNeed = 16'(DEB2);
      2'h3: debNeed = 16'(DEB3);
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      runLen_q <= 16'h0000;
    end else begin
      runLen_q <= runLen_d;
    end
  end

  sequence s_rtDrop;
    !lock_q[STICKY_BIT] && !lock_q[LCK_BYP_BIT] && !rawLock ##1 !lock_q[LCK_BYP_BIT];
  endsequence

  sequence s_unmappedAcc;
    psel && penable && !pready && !mapped;
  endsequence

  property p_bypForce;
    @(posedge ref_clk) disable iff (sys_rst) lock_q[LCK_BYP_BIT] |=> pllLocked;
  endproperty
  a_bypForce: assert property (p_bypForce) else $error("bypass did not force lock"); // RULE14

  property p_stickyHold;
    @(posedge ref_clk) disable iff (sys_rst)
      (lock_q[STICKY_BIT] && sticky_q && $stable(lock_q)) |=> pllLocked;
  endproperty
  a_stickyHold: assert property (p_stickyHold) else $error("one-time lock dropped"); // RULE12

  property p_rawPin;
    @(posedge ref_clk) disable iff (sys_rst) lock_q[RAW_PIN_BIT] |=> lockPin == $past(rawSel);
  endproperty
  a_rawPin: assert property (p_rawPin) else $error("raw lock not on pin"); // RULE9

  property p_calGate;
    @(posedge ref_clk) disable iff (sys_rst)
      (!lock_q[CAL_RUN_BIT] && !calDoneS) |-> !rawLock;
  endproperty
  a_calGate: assert property (p_calGate) else $error("detector ran before calibration"); // RULE13

  property p_noDebNeedsRaw;
    @(posedge ref_clk) disable iff (sys_rst) (!rawLock ##1 1'b1) |-> !debLock;
  endproperty
  a_noDebNeedsRaw: assert property (p_noDebNeedsRaw) else $error("lock without raw"); // RULE16

  property p_realTime;
    @(posedge ref_clk) disable iff (sys_rst) s_rtDrop |=> !pllLocked;
  endproperty
  a_realTime: assert property (p_realTime) else $error("real-time lock held"); // RULE12

  property p_resvZero;
    @(posedge ref_clk) disable iff (sys_rst)
      lock_q[15:10] == 6'h00 && pole3_q[3] == 1'b0 && srcDbl_q[7:2] == 6'h00;
  endproperty
  a_resvZero: assert property (p_resvZero) else $error("reserved bit set"); // RULE17

  property p_lpfOut;
    @(posedge ref_clk) disable iff (sys_rst)
      (wrEn && pstrb[0] && paddr == ADDR_LPF) |=>
        {vcoFilterBypass, pole_cap_code, filter_resistor_code} == $past(pwdata[7:0]);
  endproperty
  a_lpfOut: assert property (p_lpfOut) else $error("loop filter write lost"); // RULE3 RULE4 RULE5

  property p_p3Out;
    @(posedge ref_clk) disable iff (sys_rst)
      (wrEn && pstrb[0] && paddr == ADDR_POLE3) |=>
        third_pole_resistor_code == $past(pwdata[6:4]) && third_pole_cap_code == $past(pwdata[2:0]);
  endproperty
  a_p3Out: assert property (p_p3Out) else $error("third pole write lost"); // RULE7 RULE8

  property p_srcOut;
    @(posedge ref_clk) disable iff (sys_rst)
      (wrEn && pstrb[0] && paddr == ADDR_SRC_DBL) |=>
        refSelExternal == $past(pwdata[1]) && doublerEn == $past(pwdata[0]);
  endproperty
  a_srcOut: assert property (p_srcOut) else $error("source write lost"); // RULE1 RULE2

  property p_unmappedErr;
    @(posedge ref_clk) disable iff (sys_rst) s_unmappedAcc |=> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_unmappedErr: assert property (p_unmappedErr) else $error("unmapped access not refused"); // RULE17

  property p_unmappedKeep;
    @(posedge ref_clk) disable iff (sys_rst)
      s_unmappedAcc |=> $stable({srcDbl_q, lpf_q, pole3_q, lock_q});
  endproperty
  a_unmappedKeep: assert property (p_unmappedKeep) else $error("unmapped write landed"); // RULE17

  property p_statusKeep;
    @(posedge ref_clk) disable iff (sys_rst)
      (psel && penable && !pready && pwrite && paddr == ADDR_STATUS) |=>
        $stable({srcDbl_q, lpf_q, pole3_q, lock_q});
  endproperty
  a_statusKeep: assert property (p_statusKeep) else $error("status write landed"); // RULE17

  property p_lockRead;
    @(posedge ref_clk) disable iff (sys_rst)
      (psel && penable && !pready && !pwrite && paddr == ADDR_LOCK) |=>
        prdata[31:10] == 22'h00_0000 && prdata[9:0] == $past(lock_q[9:0]);
  endproperty
  a_lockRead: assert property (p_lockRead) else $error("lock register read wrong"); // RULE17

  property p_lockedPin;
    @(posedge ref_clk) disable iff (sys_rst) !lock_q[RAW_PIN_BIT] |=> lockPin == pllLocked;
  endproperty
  a_lockedPin: assert property (p_lockedPin) else $error("pin not showing lock"); // RULE9

  property p_precPin;
    @(posedge ref_clk) disable iff (sys_rst)
      (lock_q[RAW_PIN_BIT] && lock_q[PREC_EN_BIT]) |=> lockPin == $past(precS);
  endproperty
  a_precPin: assert property (p_precPin) else $error("precision raw not on pin"); // RULE10

  property p_origPin;
    @(posedge ref_clk) disable iff (sys_rst)
      (lock_q[RAW_PIN_BIT] && !lock_q[PREC_EN_BIT]) |=> lockPin == $past(origS);
  endproperty
  a_origPin: assert property (p_origPin) else $error("original raw not on pin"); // RULE10

  property p_debFollow;
    @(posedge ref_clk) disable iff (sys_rst) debLock |=> pllLocked;
  endproperty
  a_debFollow: assert property (p_debFollow) else $error("debounced lock not shown"); // RULE12

  property p_stickyClear;
    @(posedge ref_clk) disable iff (sys_rst) !lock_q[STICKY_BIT] |=> !sticky_q;
  endproperty
  a_stickyClear: assert property (p_stickyClear) else $error("sticky lock kept"); // RULE12

  property p_debInterval;
    @(posedge ref_clk) disable iff (sys_rst)
      $rose(debLock) |-> $past(rawLock) && $past(runLen_q) >= $past(debNeed);
  endproperty
  a_debInterval: assert property (p_debInterval) else $error("lock before interval"); // RULE16
endmodule

// *** dv/plcfg_pll_model.sv ***
module plcfg_pll_model (
  input wire logic ref_clk,
  input wire logic precWant,
  input wire logic origWant,
  input wire logic calWant,
  output logic precLockRaw,
  output logic origLockRaw,
  output logic calDone
);
  timeunit 1ns;
  timeprecision 1ps;
  // Analog levels move 2 ns after each rising clock edge, not on it
  initial {precLockRaw, origLockRaw, calDone} = 3'h0;
  always @(posedge ref_clk) begin
    #2 {precLockRaw, origLockRaw, calDone} <= {precWant, origWant, calWant};
  end
endmodule

// *** dv/tb_plcfg_top.sv ***
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("unexpected %s exp %0h got %0h", nm, ex, got); end end
module tb_plcfg_top;
  timeunit 1ns;
  timeprecision 1ps;
  import plcfg_pkg::*;
  localparam int D1 = 3;
  localparam int D2 = 5;
  localparam int D3 = 8;
  localparam logic [11:0] AD[4] = '{ADDR_SRC_DBL, ADDR_LPF, ADDR_POLE3, ADDR_LOCK};
  localparam logic [15:0] MK[4] = '{16'h0003, 16'h00FF, 16'h00F7, LOCK_MASK};
  logic ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [3:0] pstrb = 4'h0, s;
  logic pready, pslverr, precLockRaw, origLockRaw, calDone;
  logic precWant = 0, origWant = 0, calWant = 0;
  logic refSelExternal, doublerEn, vcoFilterBypass, third_pole_skip, precisionSelect;
  logic [2:0] pole_cap_code, third_pole_resistor_code, third_pole_cap_code, lockFilterResCode;
  logic [3:0] filter_resistor_code;
  logic lockPin, pllLocked;
  logic [15:0] eR[4] = '{16'h0001, 16'h0076, 16'h0037, 16'h0180};
  logic [32:0] expQ[$], e;
  logic [31:0] rs = 32'h0001_07DD;
  int n_mismatch = 0, n_checks = 0, n[4], m;
  int DC[4] = '{0, D1, D2, D3};

  plcfg_top #(.DEB1(D1), .DEB2(D2), .DEB3(D3)) dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .precLockRaw(precLockRaw),
    .origLockRaw(origLockRaw), .calDone(calDone), .refSelExternal(refSelExternal),
    .doublerEn(doublerEn), .vcoFilterBypass(vcoFilterBypass),
    .pole_cap_code(pole_cap_code), .filter_resistor_code(filter_resistor_code),
    .third_pole_skip(third_pole_skip), .third_pole_resistor_code(third_pole_resistor_code),
    .third_pole_cap_code(third_pole_cap_code), .precisionSelect(precisionSelect),
    .lockFilterResCode(lockFilterResCode), .lockPin(lockPin), .pllLocked(pllLocked)
  );
  plcfg_pll_model pll (
    .ref_clk(ref_clk), .precWant(precWant), .origWant(origWant), .calWant(calWant),
    .precLockRaw(precLockRaw), .origLockRaw(origLockRaw), .calDone(calDone)
  );

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------
  // APB master and response watcher
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] st, input logic [31:0] ed, input logic ee);
    expQ.push_back({ee, ed});
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= st;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  always @(posedge ref_clk) begin
    if (pready === 1'b1) begin
      if (expQ.size() == 0) `CHK("spurious", 1'b0, 1'b1)
      else begin
        e = expQ.pop_front();
        `CHK("pslverr", e[32], pslverr)
        if (!pwrite) `CHK("prdata", e[31:0], prdata)
      end
    end
  end

  task chk_outs;
    `CHK("refSel", eR[0][SRC_SEL_BIT], refSelExternal)
    `CHK("doubler", eR[0][DBL_EN_BIT], doublerEn)
    `CHK("vcoByp", eR[1][VCO_BYP_BIT], vcoFilterBypass)
    `CHK("poleCap", eR[1][6:4], pole_cap_code)
    `CHK("filtRes", eR[1][3:0], filter_resistor_code)
    `CHK("p3skip", eR[2][7], third_pole_skip)
    `CHK("p3res", eR[2][6:4], third_pole_resistor_code)
    `CHK("p3cap", eR[2][2:0], third_pole_cap_code)
    `CHK("precSel", eR[3][8], precisionSelect)
    `CHK("ldRes", eR[3][2:0], lockFilterResCode)
  endtask

  task automatic lockcfg(input logic [15:0] v);
    apb(1'b1, ADDR_LOCK, {16'h0000, v}, 4'h3, 32'h0, 1'b0);
    eR[3] = v;
  endtask

  task automatic wlk(input logic w, input int mx, output int c);
    c = 0;
    while (pllLocked !== w && c < mx) begin
      @(posedge ref_clk);
      c++;
    end
  endtask

  task automatic lat(output int c);
    precWant <= 1'b1;
    wlk(1'b1, 200, c);
    precWant <= 1'b0;
    wlk(1'b0, 200, m);
    repeat (12) @(posedge ref_clk);
  endtask

  initial begin
    #400000;
    n_mismatch++;
    end_of_test;
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    calWant <= 1'b1;
    for (int k = 0; k < 4; k++) apb(1'b0, AD[k], 32'h0, 4'h0, {16'h0, eR[k]}, 1'b0);
    chk_outs;
    for (int i = 0; i < 8; i++) begin
      for (int k = 0; k < 4; k++) begin
        r = xs();
        s = r[27:24];
        // Skip bit left clear: feedback divider mode is unknown here
        if (k == 2) r[7] = 1'b0;
        apb(1'b1, AD[k], r, s, 32'h0, 1'b0);
        eR[k] = {s[1] ? r[15:8] : eR[k][15:8], s[0] ? r[7:0] : eR[k][7:0]} & MK[k];
        apb(1'b0, AD[k], 32'h0, 4'h0, {16'h0, eR[k]}, 1'b0);
      end
      chk_outs;
    end
    apb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF, 4'hF, 32'h0, 1'b0);
    apb(1'b1, 12'h020, 32'hFFFF_FFFF, 4'hF, 32'h0, 1'b1);
    apb(1'b0, 12'h020, 32'h0, 4'h0, 32'h0, 1'b1);
    for (int k = 0; k < 4; k++) apb(1'b0, AD[k], 32'h0, 4'h0, {16'h0, eR[k]}, 1'b0);
    lockcfg(16'h0100);
    wlk(1'b0, 50, m);
    for (int c = 0; c < 4; c++) begin
      lockcfg(16'h0100 | 16'(c << 6));
      lat(n[c]);
    end
    for (int c = 1; c < 4; c++) `CHK("debounce", DC[c], n[c] - n[0])
    precWant <= 1'b1;
    repeat (6) @(posedge ref_clk);
    precWant <= 1'b0;
    repeat (2) @(posedge ref_clk);
    precWant <= 1'b1;
    repeat (6) @(posedge ref_clk);
    `CHK("glitchLock", 1'b0, pllLocked)
    wlk(1'b1, 30, m);
    `CHK("heldLock", 1'b1, pllLocked)
    lockcfg(16'h0120);
    precWant <= 1'b0;
    repeat (20) @(posedge ref_clk);
    `CHK("stickyLock", 1'b1, pllLocked)
    lockcfg(16'h0100);
    wlk(1'b0, 30, m);
    `CHK("realTime", 1'b0, pllLocked)
    calWant <= 1'b0;
    repeat (8) @(posedge ref_clk);
    precWant <= 1'b1;
    repeat (30) @(posedge ref_clk);
    `CHK("calGate", 1'b0, pllLocked)
    lockcfg(16'h0110);
    wlk(1'b1, 30, m);
    `CHK("calRun", 1'b1, pllLocked)
    precWant <= 1'b0;
    lockcfg(16'h0118);
    repeat (20) @(posedge ref_clk);
    `CHK("bypass", 1'b1, pllLocked)
    apb(1'b0, ADDR_STATUS, 32'h0, 4'h0, 32'h0000_0001, 1'b0);
    lockcfg(16'h0310);
    precWant <= 1'b1;
    repeat (8) @(posedge ref_clk);
    `CHK("rawPrec", 1'b1, lockPin)
    lockcfg(16'h0210);
    repeat (8) @(posedge ref_clk);
    `CHK("rawOrig", 1'b0, lockPin)
    origWant <= 1'b1;
    lockcfg(16'h0010);
    repeat (10) @(posedge ref_clk);
    `CHK("pinLocked", 1'b1, lockPin)
    origWant <= 1'b0;
    repeat (10) @(posedge ref_clk);
    `CHK("origSel", 1'b0, pllLocked)
    end_of_test;
  end
endmodule
